// ===== common/pmm_ext_if.sv
// link between fetch control and the external bus sequencer
`timescale 1ns/1ps
interface pmm_ext_if;
  logic start;
  logic [20:0] addr;
  logic done;
  logic [15:0] data;
  logic [15:0] ad_in;
  logic [7:0] strobes;
  logic [15:0] ad_out;
  logic ad_oe;
  logic busy;
  modport ctrl (output start, output addr, output ad_in, input done, input data,
    input strobes, input ad_out, input ad_oe, input busy);
  modport bus (input start, input addr, input ad_in, output done, output data,
    output strobes, output ad_out, output ad_oe, output busy);
endinterface : pmm_ext_if

// ===== common/pmm_pkg.sv
// shared constants and types for the program memory mode map
package pmm_pkg;

  localparam int PMM_PC_W = 21;
  localparam int PMM_KB_BYTES = 1024;
  localparam logic [20:0] PMM_SPACE_END = 21'h1FFFFF;

  // reset and interrupt entry addresses, and the fetch step
  localparam logic [20:0] PMM_VEC_RESET = 21'h000000;
  localparam logic [20:0] PMM_VEC_HIGH = 21'h000008;
  localparam logic [20:0] PMM_VEC_LOW = 21'h000018;
  localparam logic [20:0] PMM_PC_STEP = 21'h000002;

  // boot block size select
  localparam logic [1:0] PMM_BOOT_1K = 2'h0;
  localparam logic [1:0] PMM_BOOT_2K = 2'h1;
  localparam logic [1:0] PMM_BOOT_4K = 2'h2;
  localparam logic [20:0] PMM_BOOT_END_1K = 21'h000400;
  localparam logic [20:0] PMM_BOOT_END_2K = 21'h000800;
  localparam logic [20:0] PMM_BOOT_END_4K = 21'h001000;

  // strobe pin positions on the shared port
  localparam int PMM_PIN_ALE = 0;
  localparam int PMM_PIN_OE = 1;
  localparam int PMM_PIN_WRL = 2;
  localparam int PMM_PIN_WRH = 3;
  localparam int PMM_PIN_BA0 = 4;
  localparam int PMM_PIN_CE = 5;
  localparam int PMM_PIN_LB = 6;
  localparam int PMM_PIN_UB = 7;

  // data eeprom control register window in data space
  localparam logic [11:0] PMM_EE_CTL_BASE = 12'hFA0;
  localparam logic [11:0] PMM_EE_CTL_LAST = 12'hFA3;

  // idle strobe levels and the reset word
  localparam logic [7:0] PMM_STROBE_IDLE = 8'hEE;
  localparam logic [15:0] PMM_NOP_WORD = 16'h0000;

  typedef enum logic [1:0] {
    PMM_MODE_EXT = 2'b00,
    PMM_MODE_BOOT = 2'b01,
    PMM_MODE_EMC = 2'b10,
    PMM_MODE_INT = 2'b11
  } pmm_mode_t;

  typedef enum logic [1:0] {
    PMM_ROUTE_INT = 2'b00,
    PMM_ROUTE_EXT = 2'b01,
    PMM_ROUTE_ZERO = 2'b10
  } pmm_route_t;

  typedef enum logic [2:0] {
    PMM_F_IDLE = 3'b000,
    PMM_F_INT = 3'b001,
    PMM_F_INTW = 3'b010,
    PMM_F_EXT = 3'b011,
    PMM_F_ZERO = 3'b100
  } pmm_fstate_t;

  typedef enum logic [2:0] {
    PMM_X_IDLE = 3'b000,
    PMM_X_ADDR = 3'b001,
    PMM_X_HOLD = 3'b010,
    PMM_X_READ = 3'b011,
    PMM_X_WAIT = 3'b100
  } pmm_xstate_t;

endpackage : pmm_pkg

// ===== sim/pmm_ext_mem.sv
// external word-wide program memory model on the multiplexed bus
`timescale 1ns/1ps
module pmm_ext_mem
  import pmm_pkg::*;
(
  // clock
  clk,
  // bus pins
  ext_addr_hi,
  ext_ad_o,
  ext_ad_oe,
  ext_strobe_port_o,
  ext_ad_i,
  // latched address for the bench
  lat_addr
);
  input logic clk;
  input logic [4:0] ext_addr_hi;
  input logic [15:0] ext_ad_o;
  input logic ext_ad_oe;
  input logic [7:0] ext_strobe_port_o;
  output logic [15:0] ext_ad_i;
  output logic [20:0] lat_addr = 21'h000000;
  logic [15:0] word;
  logic rd_on;
  // capture address while latch enable is high
  always @(posedge clk) begin
    if (ext_strobe_port_o[PMM_PIN_ALE] === 1'b1 && ext_ad_oe === 1'b1) begin
      lat_addr <= {ext_addr_hi, ext_ad_o};
    end
  end
  assign word = lat_addr[16:1] ^ 16'h5A5A;
  // drive only with output and chip enable low
  assign rd_on = !ext_strobe_port_o[PMM_PIN_OE] && !ext_strobe_port_o[PMM_PIN_CE];
  // released bus shows the inverse
  assign ext_ad_i = rd_on ? word : ~word;
endmodule : pmm_ext_mem

// ===== sim/testbench.sv
// self-checking bench for the program memory mode map
`timescale 1ns/1ps
module testbench;
  import pmm_pkg::*;
  localparam int TB_FLASH_KB = 48;
  localparam logic [24:0] TBL [12] = '{
    {2'h3, 2'h0, 21'h00BFFE}, {2'h3, 2'h0, 21'h00C000}, {2'h0, 2'h0, 21'h000000},
    {2'h0, 2'h0, 21'h1FFFFE}, {2'h1, 2'h0, 21'h0003FE}, {2'h1, 2'h0, 21'h000400},
    {2'h1, 2'h1, 21'h0007FE}, {2'h1, 2'h1, 21'h000800}, {2'h1, 2'h2, 21'h000FFE},
    {2'h1, 2'h3, 21'h001000}, {2'h2, 2'h0, 21'h00BFFE}, {2'h2, 2'h0, 21'h00C000}};
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] mode_strap = 2'h3;
  logic [1:0] boot_size_sel = 2'h0;
  logic fetch_req = 1'b0;
  logic branch_en = 1'b0;
  logic [20:0] branch_addr = 21'h000000;
  logic irq_high = 1'b0;
  logic irq_low = 1'b0;
  logic instr_valid;
  logic [15:0] instr_data;
  logic [20:0] prog_counter;
  logic flash_rd_en;
  logic [20:0] flash_rd_addr;
  logic [15:0] flash_rd_data = 16'h0000;
  logic data_req = 1'b0;
  logic data_we = 1'b0;
  logic [11:0] data_addr = 12'h000;
  logic [7:0] data_wdata = 8'h00;
  logic ram_req;
  logic ram_we;
  logic [11:0] ram_addr;
  logic [7:0] ram_wdata;
  logic ee_ctl_sel;
  logic [1:0] ee_ctl_idx;
  logic [4:0] ext_addr_hi;
  logic [15:0] ext_ad_o;
  logic ext_ad_oe;
  logic [15:0] ext_ad_i;
  logic [7:0] ext_strobe_port_o;
  logic [7:0] ext_strobe_port_oe;
  logic [7:0] gpio_out = 8'h5A;
  logic [7:0] gpio_oe = 8'h3C;
  logic [20:0] lat_addr;
  logic [7:0] nb_strobe_oe;
  int err_total = 0;
  int n_tests = 0;
  int fl_cnt = 0;
  int ale_cnt = 0;

  pmm_top #(.FLASH_KB(TB_FLASH_KB), .HAS_EXT_BUS(1'b1)) uut (
    .clk(clk), .reset_n(reset_n), .memory_mode_config_byte(mode_strap),
    .boot_size_sel(boot_size_sel), .fetch_req(fetch_req), .branch_en(branch_en),
    .branch_addr(branch_addr), .irq_high(irq_high), .irq_low(irq_low),
    .instr_valid(instr_valid), .instr_data(instr_data), .prog_counter(prog_counter),
    .flash_rd_en(flash_rd_en), .flash_rd_addr(flash_rd_addr), .flash_rd_data(flash_rd_data),
    .data_req(data_req), .data_we(data_we), .data_addr(data_addr), .data_wdata(data_wdata),
    .ram_req(ram_req), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ee_ctl_sel(ee_ctl_sel), .ee_ctl_idx(ee_ctl_idx), .ext_addr_hi(ext_addr_hi),
    .ext_ad_o(ext_ad_o), .ext_ad_oe(ext_ad_oe), .ext_ad_i(ext_ad_i),
    .ext_strobe_port_o(ext_strobe_port_o), .ext_strobe_port_oe(ext_strobe_port_oe),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe));

  pmm_ext_mem partner (
    .clk(clk), .ext_addr_hi(ext_addr_hi), .ext_ad_o(ext_ad_o), .ext_ad_oe(ext_ad_oe),
    .ext_strobe_port_o(ext_strobe_port_o), .ext_ad_i(ext_ad_i), .lat_addr(lat_addr));

  // variant without the external bus, sharing every input
  pmm_top #(.FLASH_KB(TB_FLASH_KB), .HAS_EXT_BUS(1'b0)) uut_nobus (
    .clk(clk), .reset_n(reset_n), .memory_mode_config_byte(mode_strap),
    .boot_size_sel(boot_size_sel), .fetch_req(fetch_req), .branch_en(branch_en),
    .branch_addr(branch_addr), .irq_high(irq_high), .irq_low(irq_low),
    .instr_valid(), .instr_data(), .prog_counter(),
    .flash_rd_en(), .flash_rd_addr(), .flash_rd_data(flash_rd_data),
    .data_req(data_req), .data_we(data_we), .data_addr(data_addr), .data_wdata(data_wdata),
    .ram_req(), .ram_we(), .ram_addr(), .ram_wdata(),
    .ee_ctl_sel(), .ee_ctl_idx(), .ext_addr_hi(),
    .ext_ad_o(), .ext_ad_oe(), .ext_ad_i(ext_ad_i),
    .ext_strobe_port_o(), .ext_strobe_port_oe(nb_strobe_oe),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe));

  always #2.5 clk = ~clk;

  // flash model and strobe monitor
  always @(posedge clk) begin
    if (flash_rd_en === 1'b1) begin
      flash_rd_data <= flash_rd_addr[16:1] ^ 16'h3C3C;
      fl_cnt++;
    end else begin
      flash_rd_data <= ~flash_rd_data;
    end
    if (ext_strobe_port_o[PMM_PIN_ALE] === 1'b1 && ext_ad_oe === 1'b1) begin
      ale_cnt++;
      chk(ext_strobe_port_oe, 8'hFF);
      chk(ext_strobe_port_o, 8'h0F);
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk

  function automatic int route_of(input logic [1:0] m, input logic [1:0] b,
      input logic [20:0] a);
    logic [20:0] bend;
    logic [20:0] fend;
    bend = (b == 2'h0) ? 21'h000400 : (b == 2'h1) ? 21'h000800 : 21'h001000;
    fend = 21'(TB_FLASH_KB * 1024);
    case (m)
      2'h0: return 1;
      2'h1: return (a < bend) ? 0 : 1;
      2'h2: return (a < fend) ? 0 : 1;
      default: return (a < fend) ? 0 : 2;
    endcase
  endfunction : route_of

  task automatic restart(input logic [1:0] m, input logic [1:0] b);
    @(posedge clk) begin
      reset_n <= 1'b0;
      mode_strap <= m;
      boot_size_sel <= b;
    end
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(prog_counter, 21'h000000);
  endtask : restart

  task automatic wait_valid();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (instr_valid !== 1'b1 && n < 12);
    chk(instr_valid, 1'b1);
  endtask : wait_valid

  task automatic fetch(input logic [1:0] m, input logic [1:0] b, input logic [20:0] a);
    int r;
    int f0;
    int x0;
    logic [15:0] e;
    r = route_of(m, b, a);
    e = (r == 0) ? (a[16:1] ^ 16'h3C3C) : (r == 1) ? (a[16:1] ^ 16'h5A5A) : 16'h0000;
    f0 = fl_cnt;
    x0 = ale_cnt;
    @(posedge clk) begin
      branch_addr <= a;
      branch_en <= 1'b1;
    end
    @(posedge clk) begin
      branch_en <= 1'b0;
      fetch_req <= 1'b1;
    end
    #1;
    chk(prog_counter, a);
    @(posedge clk) fetch_req <= 1'b0;
    wait_valid();
    chk(instr_data, e);
    @(posedge clk);
    #1;
    chk(prog_counter, 21'(a + 21'h000002));
    chk(fl_cnt - f0, (r == 0));
    chk(ale_cnt - x0, (r == 1));
    if (r == 1) chk(lat_addr, a);
  endtask : fetch

  task automatic t_route();
    for (int i = 0; i < 12; i++) begin
      restart(TBL[i][24:23], TBL[i][22:21]);
      fetch(TBL[i][24:23], TBL[i][22:21], TBL[i][20:0]);
    end
    $display("test route done");
  endtask : t_route

  task automatic t_irq();
    restart(2'h3, 2'h0);
    @(posedge clk) irq_low <= 1'b1;
    @(posedge clk) irq_low <= 1'b0;
    #1;
    chk(prog_counter, 21'h000018);
    @(posedge clk) begin
      irq_high <= 1'b1;
      irq_low <= 1'b1;
    end
    @(posedge clk) begin
      irq_high <= 1'b0;
      irq_low <= 1'b0;
    end
    #1;
    chk(prog_counter, 21'h000008);
    $display("test irq done");
  endtask : t_irq

  task automatic t_gpio();
    restart(2'h3, 2'h0);
    chk(ext_strobe_port_o, 8'h5A);
    chk(ext_strobe_port_oe, 8'h3C);
    @(posedge clk) gpio_out <= 8'hC3;
    @(posedge clk);
    #1;
    chk(ext_strobe_port_o, 8'hC3);
    $display("test gpio done");
  endtask : t_gpio

  task automatic t_data();
    restart(2'h0, 2'h0);
    chk(nb_strobe_oe, 8'h3C);
    chk(ext_strobe_port_oe, 8'hFF);
    @(posedge clk) begin
      data_req <= 1'b1;
      data_we <= 1'b1;
      data_addr <= 12'hFA2;
      data_wdata <= 8'hA5;
      fetch_req <= 1'b1;
    end
    @(posedge clk) begin
      data_addr <= 12'h123;
      fetch_req <= 1'b0;
    end
    #1;
    chk(ee_ctl_sel, 1'b1);
    chk(ee_ctl_idx, 2'h2);
    chk(ram_req, 1'b0);
    @(posedge clk) data_req <= 1'b0;
    #1;
    chk({ram_req, ram_we, ee_ctl_sel}, 3'h6);
    chk({ram_addr, ram_wdata}, 20'h123A5);
    wait_valid();
    chk(instr_data, 16'h5A5A);
    $display("test data done");
  endtask : t_data

  task automatic tally_and_finish();
    $display("counts: %0d checks, %0d mismatches", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    t_route();
    t_irq();
    t_gpio();
    t_data();
    tally_and_finish();
  end

  initial begin
    #50000;
    err_total++;
    tally_and_finish();
  end
endmodule : testbench

// ===== verilog/pmm_ext_bus.sv
// external program memory read cycle sequencer
`timescale 1ns/1ps
module pmm_ext_bus
  import pmm_pkg::*;
(
  // clock and reset
  input logic clk,
  input logic reset_n,
  // sequencer side of the link
  pmm_ext_if.bus ext
);

  pmm_xstate_t state_reg;
  logic done_reg;
  logic [15:0] data_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= PMM_X_IDLE;
    end else begin
      case (state_reg)
        PMM_X_IDLE: if (ext.start) state_reg <= PMM_X_ADDR;
        PMM_X_ADDR: state_reg <= PMM_X_HOLD;
        PMM_X_HOLD: state_reg <= PMM_X_READ;
        PMM_X_READ: state_reg <= PMM_X_WAIT;
        PMM_X_WAIT: state_reg <= PMM_X_IDLE;
        default: state_reg <= PMM_X_IDLE;
      endcase
    end
  end

  // capture the word once output enable has stood a cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done_reg <= 1'b0;
      data_reg <= PMM_NOP_WORD;
    end else begin
      done_reg <= (state_reg == PMM_X_WAIT);
      if (state_reg == PMM_X_WAIT) data_reg <= ext.ad_in;
    end
  end

  // strobes, active low except latch enable; fetches never write
  always_comb begin
    ext.strobes = PMM_STROBE_IDLE;
    ext.strobes[PMM_PIN_BA0] = ext.addr[0];
    if (state_reg != PMM_X_IDLE) begin
      ext.strobes[PMM_PIN_CE] = 1'b0;
      ext.strobes[PMM_PIN_LB] = 1'b0;
      ext.strobes[PMM_PIN_UB] = 1'b0;
    end
    ext.strobes[PMM_PIN_ALE] = (state_reg == PMM_X_ADDR);
    ext.strobes[PMM_PIN_OE] = !((state_reg == PMM_X_READ) || (state_reg == PMM_X_WAIT));
  end

  assign ext.ad_out = ext.addr[15:0];
  assign ext.ad_oe = (state_reg == PMM_X_ADDR);
  assign ext.busy = (state_reg != PMM_X_IDLE);
  assign ext.done = done_reg;
  assign ext.data = data_reg;

endmodule : pmm_ext_bus

// ===== verilog/pmm_top.sv
// program memory mode map: fetch routing, external bus pins, data path
`timescale 1ns/1ps

module pmm_top
  import pmm_pkg::*;
#(
  parameter int FLASH_KB = 48,
  parameter bit HAS_EXT_BUS = 1'b1
) (
  // clock and reset
  input logic clk,
  input logic reset_n,
  // configuration straps
  input logic [1:0] memory_mode_config_byte,
  input logic [1:0] boot_size_sel,
  // core fetch port
  input logic fetch_req,
  input logic branch_en,
  input logic [20:0] branch_addr,
  input logic irq_high,
  input logic irq_low,
  output logic instr_valid,
  output logic [15:0] instr_data,
  output logic [20:0] prog_counter,
  // on-chip flash read port
  output logic flash_rd_en,
  output logic [20:0] flash_rd_addr,
  input logic [15:0] flash_rd_data,
  // core data port
  input logic data_req,
  input logic data_we,
  input logic [11:0] data_addr,
  input logic [7:0] data_wdata,
  output logic ram_req,
  output logic ram_we,
  output logic [11:0] ram_addr,
  output logic [7:0] ram_wdata,
  output logic ee_ctl_sel,
  output logic [1:0] ee_ctl_idx,
  // external bus pins
  output logic [4:0] ext_addr_hi,
  output logic [15:0] ext_ad_o,
  output logic ext_ad_oe,
  input logic [15:0] ext_ad_i,
  // shared strobe port and its general purpose use
  output logic [7:0] ext_strobe_port_o,
  output logic [7:0] ext_strobe_port_oe,
  input logic [7:0] gpio_out,
  input logic [7:0] gpio_oe
);
  import pmm_pkg::*;

  localparam logic [20:0] FLASH_END = 21'(FLASH_KB * PMM_KB_BYTES);

  function automatic logic [20:0] boot_end_of(input logic [1:0] sel);
    case (sel)
      PMM_BOOT_1K: boot_end_of = PMM_BOOT_END_1K;
      PMM_BOOT_2K: boot_end_of = PMM_BOOT_END_2K;
      default: boot_end_of = PMM_BOOT_END_4K;
    endcase
  endfunction : boot_end_of

  function automatic pmm_route_t route_of(input pmm_mode_t m, input logic [20:0] a,
      input logic [20:0] boot_end);
    case (m)
      PMM_MODE_EXT: route_of = PMM_ROUTE_EXT;
      PMM_MODE_BOOT: route_of = (a < boot_end) ? PMM_ROUTE_INT : PMM_ROUTE_EXT;
      PMM_MODE_EMC: route_of = (a < FLASH_END) ? PMM_ROUTE_INT : PMM_ROUTE_EXT;
      default: route_of = (a < FLASH_END) ? PMM_ROUTE_INT : PMM_ROUTE_ZERO;
    endcase
  endfunction : route_of

  pmm_ext_if ext ();

  pmm_ext_bus u_ext_bus (
    .clk(clk),
    .reset_n(reset_n),
    .ext(ext)
  );

  pmm_mode_t mode_reg;
  logic [1:0] boot_sel_reg;
  logic cfg_taken_reg;
  logic [20:0] pc_reg;
  pmm_fstate_t fstate_reg;
  logic instr_valid_reg;
  logic [15:0] instr_data_reg;
  logic flash_rd_en_reg;
  logic [20:0] flash_rd_addr_reg;
  logic ext_start_reg;
  logic ram_req_reg;
  logic ram_we_reg;
  logic [11:0] ram_addr_reg;
  logic [7:0] ram_wdata_reg;
  logic ee_ctl_sel_reg;
  logic [1:0] ee_ctl_idx_reg;
  logic [4:0] ext_addr_hi_reg;
  logic [15:0] ext_ad_o_reg;
  logic ext_ad_oe_reg;
  logic [7:0] strobe_o_reg;
  logic [7:0] strobe_oe_reg;
  logic redirect;
  logic take;
  logic ext_used;
  logic ee_hit;
  logic [20:0] boot_end;
  pmm_route_t route;

  // straps caught on the first edge after reset release
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_reg <= PMM_MODE_INT;
      boot_sel_reg <= PMM_BOOT_1K;
      cfg_taken_reg <= 1'b0;
    end else if (!cfg_taken_reg) begin
      cfg_taken_reg <= 1'b1;
      boot_sel_reg <= boot_size_sel;
      if (HAS_EXT_BUS) begin
        mode_reg <= pmm_mode_t'(memory_mode_config_byte);
      end else begin
        mode_reg <= PMM_MODE_INT;
      end
    end
  end

  assign boot_end = boot_end_of(boot_sel_reg);
  assign route = route_of(mode_reg, pc_reg, boot_end);
  assign redirect = irq_high || irq_low || branch_en;
  assign take = cfg_taken_reg && (fstate_reg == PMM_F_IDLE) && !redirect && fetch_req;
  assign ext_used = (mode_reg != PMM_MODE_INT);

  // program counter and vectors
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_reg <= PMM_VEC_RESET;
    end else if (cfg_taken_reg && (fstate_reg == PMM_F_IDLE) && redirect) begin
      if (irq_high) begin
        pc_reg <= PMM_VEC_HIGH;
      end else if (irq_low) begin
        pc_reg <= PMM_VEC_LOW;
      end else begin
        pc_reg <= branch_addr;
      end
    end else if (instr_valid_reg) begin
      pc_reg <= pc_reg + PMM_PC_STEP;
    end
  end

  // fetch sequencing
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fstate_reg <= PMM_F_IDLE;
    end else begin
      case (fstate_reg)
        PMM_F_IDLE: begin
          if (take) begin
            case (route)
              PMM_ROUTE_INT: fstate_reg <= PMM_F_INT;
              PMM_ROUTE_EXT: fstate_reg <= PMM_F_EXT;
              default: fstate_reg <= PMM_F_ZERO;
            endcase
          end
        end
        PMM_F_INT: fstate_reg <= PMM_F_INTW;
        PMM_F_INTW: fstate_reg <= PMM_F_IDLE;
        PMM_F_EXT: if (ext.done) fstate_reg <= PMM_F_IDLE;
        PMM_F_ZERO: fstate_reg <= PMM_F_IDLE;
        default: fstate_reg <= PMM_F_IDLE;
      endcase
    end
  end

  // flash read and external start requests
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flash_rd_en_reg <= 1'b0;
      flash_rd_addr_reg <= PMM_VEC_RESET;
      ext_start_reg <= 1'b0;
    end else begin
      flash_rd_en_reg <= take && (route == PMM_ROUTE_INT);
      ext_start_reg <= take && (route == PMM_ROUTE_EXT);
      if (take) flash_rd_addr_reg <= pc_reg;
    end
  end

  // instruction word answer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      instr_valid_reg <= 1'b0;
      instr_data_reg <= PMM_NOP_WORD;
    end else begin
      instr_valid_reg <= 1'b0;
      case (fstate_reg)
        PMM_F_INTW: begin
          instr_valid_reg <= 1'b1;
          instr_data_reg <= flash_rd_data;
        end
        PMM_F_EXT: begin
          if (ext.done) begin
            instr_valid_reg <= 1'b1;
            instr_data_reg <= ext.data;
          end
        end
        PMM_F_ZERO: begin
          instr_valid_reg <= 1'b1;
          instr_data_reg <= PMM_NOP_WORD;
        end
        default: instr_valid_reg <= 1'b0;
      endcase
    end
  end

  assign ext.start = ext_start_reg;
  assign ext.addr = pc_reg;
  assign ext.ad_in = ext_ad_i;

  // external bus and shared strobe pins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_addr_hi_reg <= 5'h00;
      ext_ad_o_reg <= 16'h0000;
      ext_ad_oe_reg <= 1'b0;
      strobe_o_reg <= 8'h00;
      strobe_oe_reg <= 8'h00;
    end else begin
      ext_addr_hi_reg <= ext.addr[20:16];
      ext_ad_o_reg <= ext.ad_out;
      ext_ad_oe_reg <= ext_used && ext.ad_oe;
      if (ext_used) begin
        strobe_o_reg <= ext.strobes;
        strobe_oe_reg <= 8'hFF;
      end else begin
        strobe_o_reg <= gpio_out;
        strobe_oe_reg <= gpio_oe;
      end
    end
  end

  // data side runs apart from fetch and from the mode
  assign ee_hit = (data_addr >= PMM_EE_CTL_BASE) && (data_addr <= PMM_EE_CTL_LAST);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ram_req_reg <= 1'b0;
      ram_we_reg <= 1'b0;
      ram_addr_reg <= 12'h000;
      ram_wdata_reg <= 8'h00;
      ee_ctl_sel_reg <= 1'b0;
      ee_ctl_idx_reg <= 2'h0;
    end else begin
      ram_req_reg <= data_req && !ee_hit;
      ee_ctl_sel_reg <= data_req && ee_hit;
      ee_ctl_idx_reg <= data_addr[1:0];
      ram_we_reg <= data_we;
      ram_addr_reg <= data_addr;
      ram_wdata_reg <= data_wdata;
    end
  end

  assign instr_valid = instr_valid_reg;
  assign instr_data = instr_data_reg;
  assign prog_counter = pc_reg;
  assign flash_rd_en = flash_rd_en_reg;
  assign flash_rd_addr = flash_rd_addr_reg;
  assign ram_req = ram_req_reg;
  assign ram_we = ram_we_reg;
  assign ram_addr = ram_addr_reg;
  assign ram_wdata = ram_wdata_reg;
  assign ee_ctl_sel = ee_ctl_sel_reg;
  assign ee_ctl_idx = ee_ctl_idx_reg;
  assign ext_addr_hi = ext_addr_hi_reg;
  assign ext_ad_o = ext_ad_o_reg;
  assign ext_ad_oe = ext_ad_oe_reg;
  assign ext_strobe_port_o = strobe_o_reg;
  assign ext_strobe_port_oe = strobe_oe_reg;

  // checks
  AST_RESET_PC: assert property (@(posedge clk) disable iff (!reset_n)
    !cfg_taken_reg |=> pc_reg == PMM_VEC_RESET)
    else $error("pc not at zero before first fetch");

  AST_VEC_HIGH: assert property (@(posedge clk) disable iff (!reset_n)
    cfg_taken_reg && fstate_reg == PMM_F_IDLE && irq_high |=> pc_reg == PMM_VEC_HIGH)
    else $error("high interrupt entry wrong");

  AST_VEC_LOW: assert property (@(posedge clk) disable iff (!reset_n)
    cfg_taken_reg && fstate_reg == PMM_F_IDLE && !irq_high && irq_low
    |=> pc_reg == PMM_VEC_LOW)
    else $error("low interrupt entry wrong");

  AST_ZERO_READ: assert property (@(posedge clk) disable iff (!reset_n)
    take && mode_reg == PMM_MODE_INT && pc_reg >= FLASH_END
    |=> ##1 instr_valid_reg && instr_data_reg == PMM_NOP_WORD && !flash_rd_en_reg)
    else $error("read above flash not zero");

  AST_EXT_NO_FLASH: assert property (@(posedge clk) disable iff (!reset_n)
    cfg_taken_reg && mode_reg == PMM_MODE_EXT |-> !flash_rd_en_reg)
    else $error("flash used in external-only mode");

  AST_BOOT_LIMIT: assert property (@(posedge clk) disable iff (!reset_n)
    take && mode_reg == PMM_MODE_BOOT |=> flash_rd_en_reg == (flash_rd_addr_reg < boot_end))
    else $error("boot block split wrong");

  AST_INT_LAT: assert property (@(posedge clk) disable iff (!reset_n)
    take && route == PMM_ROUTE_INT
    |=> flash_rd_en_reg ##1 !instr_valid_reg ##1 instr_valid_reg)
    else $error("internal fetch timing wrong");

  AST_EXT_LAT: assert property (@(posedge clk) disable iff (!reset_n)
    take && route == PMM_ROUTE_EXT
    |=> ##1 !strobe_o_reg[PMM_PIN_ALE] ##1 strobe_o_reg[PMM_PIN_ALE] && ext_ad_oe_reg
    ##2 !strobe_o_reg[PMM_PIN_OE] && !strobe_o_reg[PMM_PIN_CE] ##2 instr_valid_reg)
    else $error("external fetch sequence wrong");

  AST_NO_BUS_GPIO: assert property (@(posedge clk) disable iff (!reset_n)
    cfg_taken_reg && mode_reg == PMM_MODE_INT |=> strobe_oe_reg == $past(gpio_oe))
    else $error("strobe pins not released to port");

  AST_FORCED_INT: assert property (@(posedge clk) disable iff (!reset_n)
    cfg_taken_reg && !HAS_EXT_BUS |-> mode_reg == PMM_MODE_INT)
    else $error("mode not forced without bus");

  AST_DATA_PASS: assert property (@(posedge clk) disable iff (!reset_n)
    data_req && !ee_hit |=> ram_req_reg && ram_addr_reg == $past(data_addr))
    else $error("data ram access lost");

  AST_EE_WINDOW: assert property (@(posedge clk) disable iff (!reset_n)
    data_req && ee_hit |=> ee_ctl_sel_reg && !ram_req_reg)
    else $error("eeprom control access misrouted");

  AST_EXT_BUSY: assert property (@(posedge clk) disable iff (!reset_n)
    ext.busy |-> fstate_reg == PMM_F_EXT)
    else $error("external cycle outside fetch");

endmodule : pmm_top
